// ==== jkf_pkg.sv ====
// constants for the dual jk storage element block
// assumes one core clock; all element pins arrive asynchronously
//
// Summary of operation
// [RULE1] The block holds two storage elements that share no inputs or state.
// [RULE2] Apart from preset, an element changes only on a falling edge of its own clock pin.
// [RULE3] Data levels may change while the clock is high; edge-prior ones act.
// [RULE4] The driver holds load_one and load_zero steady around each falling edge.
// [RULE5] A low preset forces q high and q_n low whatever clock and data do.
// [RULE6] Preset needs no clock edge of the element and beats any update.
// [RULE7] At a fall: 0/1 gives q low, 1/0 gives q high, 0/0 holds.
// [RULE8] The next state uses data and state from just before the edge.
// [RULE9] At a fall with both data high q inverts; q_n is always ~q.
package jkf_pkg;
	localparam int   JKF_ELEMENTS = 2;
	localparam logic JKF_Q_RST    = 1'b0;
	localparam logic JKF_CLK_RST  = 1'b0;
	localparam logic JKF_DATA_RST = 1'b0;
	localparam logic JKF_PRE_RST  = 1'b1;
endpackage

// ==== jkf_dual.sv ====
// dual falling-edge jk storage elements with active-low preset
// assumes pins are asynchronous to core_clk and far slower than it
// q and q_n land four core edges after a pin change
`timescale 1ns/1ps
module jkf_dual
	import jkf_pkg::*;
#(
	parameter int N = JKF_ELEMENTS
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [N-1:0] falling_edge_clock,
	input  wire logic [N-1:0] load_one,
	input  wire logic [N-1:0] load_zero,
	input  wire logic [N-1:0] preset_n,
	output logic      [N-1:0] q,
	output logic      [N-1:0] q_n
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [N-1:0] clk_s1;
		logic [N-1:0] clk_s2;
		logic [N-1:0] clk_s3;
		logic [N-1:0] clk_f;
		logic [N-1:0] j_s1;
		logic [N-1:0] j_s2;
		logic [N-1:0] j_s3;
		logic [N-1:0] j_f;
		logic [N-1:0] k_s1;
		logic [N-1:0] k_s2;
		logic [N-1:0] k_s3;
		logic [N-1:0] k_f;
		logic [N-1:0] p_s1;
		logic [N-1:0] p_s2;
		logic [N-1:0] p_s3;
		logic [N-1:0] p_f;
		logic [N-1:0] q;
		logic [N-1:0] qn;
	} jkf_state_t;

	jkf_state_t   st_q;
	jkf_state_t   st_d;
	logic [N-1:0] fall_ev;
	logic [N-1:0] set_act;

	// ------------------------------------------------------------
	// pin filter
	// ------------------------------------------------------------
	// level counts once stages two and three agree
	function automatic logic [N-1:0] agree(
		input logic [N-1:0] old,
		input logic [N-1:0] s2,
		input logic [N-1:0] s3
	);
		agree = ((s2 ~^ s3) & s2) | ((s2 ^ s3) & old);
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [N-1:0] clk_new;
		logic [N-1:0] pre_new;
		clk_new = '0;
		pre_new = '0;
		st_d = st_q;
		st_d.clk_s1 = falling_edge_clock;
		st_d.clk_s2 = st_q.clk_s1;
		st_d.clk_s3 = st_q.clk_s2;
		st_d.j_s1   = load_one;
		st_d.j_s2   = st_q.j_s1;
		st_d.j_s3   = st_q.j_s2;
		st_d.k_s1   = load_zero;
		st_d.k_s2   = st_q.k_s1;
		st_d.k_s3   = st_q.k_s2;
		st_d.p_s1   = preset_n;
		st_d.p_s2   = st_q.p_s1;
		st_d.p_s3   = st_q.p_s2;
		clk_new = agree(st_q.clk_f, st_q.clk_s2, st_q.clk_s3);
		pre_new = agree(st_q.p_f, st_q.p_s2, st_q.p_s3);
		st_d.clk_f = clk_new;
		st_d.p_f   = pre_new;
		// data filter keeps following while clock is high
		st_d.j_f = agree(st_q.j_f, st_q.j_s2, st_q.j_s3); // RULE3
		st_d.k_f = agree(st_q.k_f, st_q.k_s2, st_q.k_s3); // RULE3
		fall_ev = st_q.clk_f & ~clk_new; // RULE2
		set_act = ~pre_new;
		for (int i = 0; i < N; i++) begin // RULE1
			if (set_act[i]) begin
				st_d.q[i] = 1'b1; // RULE5 RULE6
			end else if (fall_ev[i]) begin
				// old filtered levels are the pre-edge ones
				unique case ({st_q.j_f[i], st_q.k_f[i]}) // RULE8
					2'b00: st_d.q[i] = st_q.q[i]; // RULE7
					2'b01: st_d.q[i] = 1'b0; // RULE7
					2'b10: st_d.q[i] = 1'b1; // RULE7
					2'b11: st_d.q[i] = ~st_q.q[i]; // RULE9
				endcase
			end
			st_d.qn[i] = ~st_d.q[i]; // RULE9 RULE5
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q.clk_s1 <= {N{JKF_CLK_RST}};
			st_q.clk_s2 <= {N{JKF_CLK_RST}};
			st_q.clk_s3 <= {N{JKF_CLK_RST}};
			st_q.clk_f  <= {N{JKF_CLK_RST}};
			st_q.j_s1   <= {N{JKF_DATA_RST}};
			st_q.j_s2   <= {N{JKF_DATA_RST}};
			st_q.j_s3   <= {N{JKF_DATA_RST}};
			st_q.j_f    <= {N{JKF_DATA_RST}};
			st_q.k_s1   <= {N{JKF_DATA_RST}};
			st_q.k_s2   <= {N{JKF_DATA_RST}};
			st_q.k_s3   <= {N{JKF_DATA_RST}};
			st_q.k_f    <= {N{JKF_DATA_RST}};
			st_q.p_s1   <= {N{JKF_PRE_RST}};
			st_q.p_s2   <= {N{JKF_PRE_RST}};
			st_q.p_s3   <= {N{JKF_PRE_RST}};
			st_q.p_f    <= {N{JKF_PRE_RST}};
			st_q.q      <= {N{JKF_Q_RST}};
			st_q.qn     <= {N{~JKF_Q_RST}};
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign q   = st_q.q;
	assign q_n = st_q.qn;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	for (genvar g = 0; g < N; g++) begin : g_chk
		preset_forces_high_a: assert property ( // RULE5
			!st_q.p_f[g] |-> (q[g] && !q_n[g]))
			else $error("preset low but q not forced high");
		preset_beats_edge_a: assert property ( // RULE6
			(set_act[g] && fall_ev[g]) |=> q[g] ##1 (q[g] || !st_q.p_f[g]
				|| fall_ev[g] || $past(fall_ev[g])))
			else $error("clock edge overrode preset");
		outputs_complement_a: assert property ( // RULE9
			q_n[g] == ~q[g])
			else $error("q_n is not the inverse of q");
		change_needs_fall_a: assert property ( // RULE2
			!$stable(q[g]) |-> $past(fall_ev[g] || set_act[g]))
			else $error("q changed without falling edge or preset");
		load_zero_a: assert property ( // RULE7
			(fall_ev[g] && !set_act[g] && !st_q.j_f[g] && st_q.k_f[g])
				|=> !q[g])
			else $error("load zero did not clear q");
		load_one_a: assert property ( // RULE7
			(fall_ev[g] && !set_act[g] && st_q.j_f[g] && !st_q.k_f[g])
				|=> q[g])
			else $error("load one did not set q");
		hold_state_a: assert property ( // RULE7
			(fall_ev[g] && !set_act[g] && !st_q.j_f[g] && !st_q.k_f[g])
				|=> $stable(q[g]))
			else $error("hold edge changed q");
		toggle_state_a: assert property ( // RULE9
			(fall_ev[g] && !set_act[g] && st_q.j_f[g] && st_q.k_f[g])
				|=> q[g] != $past(q[g]))
			else $error("toggle edge did not invert q");
		edge_latency_a: assert property ( // RULE2
			$fell(st_q.clk_s2[g]) && st_q.clk_s3[g] && st_q.clk_f[g]
				|=> fall_ev[g])
			else $error("falling edge not seen on next cycle");
		edge_once_a: assert property ( // RULE2
			fall_ev[g] |=> !fall_ev[g])
			else $error("one clock fall counted twice");
		no_rise_update_a: assert property ( // RULE2
			$rose(st_q.clk_f[g]) && st_q.p_f[g] |-> $stable(q[g]))
			else $error("q changed on a rising clock");
		j_filter_a: assert property ( // RULE3
			(st_q.j_s2[g] == st_q.j_s3[g]) |=> st_q.j_f[g] == $past(st_q.j_s2[g]))
			else $error("load_one filter did not follow settled level");
		k_filter_a: assert property ( // RULE3
			(st_q.k_s2[g] == st_q.k_s3[g]) |=> st_q.k_f[g] == $past(st_q.k_s2[g]))
			else $error("load_zero filter did not follow settled level");
		quiet_element_a: assert property ( // RULE1
			!fall_ev[g] && !set_act[g] |=> $stable(q[g]))
			else $error("q changed without its own edge or preset");
		preset_any_time_a: assert property ( // RULE6
			set_act[g] |=> q[g] && !q_n[g])
			else $error("active preset did not force q high");
		preset_latency_a: assert property ( // RULE6
			$fell(st_q.p_s2[g]) && !st_q.p_s1[g] |=> set_act[g])
			else $error("settled low preset not acted on");
		preset_filter_a: assert property ( // RULE6
			(st_q.p_s2[g] == st_q.p_s3[g]) |=> st_q.p_f[g] == $past(st_q.p_s2[g]))
			else $error("preset filter did not follow settled level");

		// --------------------------------------------------------
		// covers
		// --------------------------------------------------------
		toggle_c: cover property (
			fall_ev[g] && !set_act[g] && st_q.j_f[g] && st_q.k_f[g]);
		preset_c: cover property (set_act[g] && fall_ev[g]);
		clear_c: cover property ($fell(q[g]));
		hold_c: cover property (
			fall_ev[g] && !set_act[g] && !st_q.j_f[g] && !st_q.k_f[g]);
		load_one_c: cover property (
			fall_ev[g] && !set_act[g] && st_q.j_f[g] && !st_q.k_f[g]);
	end

endmodule

// ==== placeholder_none.sv ====
`timescale 1ns/1ps

// ==== jkf_partner.sv ====
// upstream logic model driving the element pins
// assumes a free-running core_clk
`timescale 1ns/1ps
module jkf_partner
	import jkf_pkg::*;
#(
	parameter int N = JKF_ELEMENTS
) (
	input  wire logic         core_clk,
	output logic      [N-1:0] falling_edge_clock,
	output logic      [N-1:0] load_one,
	output logic      [N-1:0] load_zero,
	output logic      [N-1:0] preset_n
);
	initial begin
		falling_edge_clock = '1;
		load_one = '0;
		load_zero = '0;
		preset_n = '1;
	end
	// data set while high, held across the fall
	task automatic pulse(input int e, input logic j, input logic k);
		load_one[e] <= j;
		load_zero[e] <= k;
		repeat (4) @(posedge core_clk);
		falling_edge_clock[e] <= 1'b0;
		repeat (4) @(posedge core_clk);
		falling_edge_clock[e] <= 1'b1;
		load_one[e] <= ~j;
		load_zero[e] <= ~k;
		repeat (4) @(posedge core_clk);
	endtask
	task automatic set_pulse(input int e);
		preset_n[e] <= 1'b0;
		repeat (6) @(posedge core_clk);
		preset_n[e] <= 1'b1;
		repeat (6) @(posedge core_clk);
	endtask
endmodule

// ==== jkf_dual_bench.sv ====
// bench: random steps and presets against an integer model
// assumes jkf_dual and jkf_partner with two elements
`timescale 1ns/1ps
module jkf_dual_bench;
	import jkf_pkg::*;
	logic       core_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [1:0] falling_edge_clock, load_one, load_zero, preset_n, q, q_n;
	int         miscompares = 0, checked = 0, e, m[2] = '{0, 0};
	logic [31:0] seed = 32'hC6FA;
	always #5 core_clk = ~core_clk;
	jkf_dual jkf_dual_inst (.core_clk, .rst_n, .falling_edge_clock,
		.load_one, .load_zero, .preset_n, .q, .q_n);
	jkf_partner jkf_partner_inst (.core_clk, .falling_edge_clock,
		.load_one, .load_zero, .preset_n);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp_q;
		logic [1:0] x;
		x = {m[1][0], m[0][0]};
		checked++;
		if (q !== x || q_n !== ~x) begin
			miscompares++;
			$display("wrong value at %0t: q %h q_n %h exp %h",
				$time, q, q_n, x);
		end
	endtask
	task automatic tally_and_finish;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		cmp_q();
		for (int i = 0; i < 60; i++) begin
			seed = lfsr(seed);
			e = seed[0];
			if (seed[5:3] == 3'h0) begin
				jkf_partner_inst.set_pulse(e);
				m[e] = 1;
				cmp_q();
			end else begin
				jkf_partner_inst.pulse(e, seed[1], seed[2]);
				m[e] = seed[1] & seed[2] ? !m[e] :
					seed[1] ? 1 : seed[2] ? 0 : m[e];
				cmp_q();
			end
		end
		$display("test random steps done");
		fork
			jkf_partner_inst.pulse(0, 1'b0, 1'b1);
			jkf_partner_inst.set_pulse(0);
		join
		m[0] = 1;
		cmp_q();
		$display("test preset override done");
		tally_and_finish();
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		tally_and_finish();
	end
endmodule
